/* hw/infrared_endec_consts.vh */
/*
 * Register indices, field positions, reset values and bit timing of the
 * infrared pulse encoder/decoder.
 * Assumes it is included by bare name from the design files.
 */
`ifndef INFRARED_ENDEC_CONSTS_VH
`define INFRARED_ENDEC_CONSTS_VH

// Register indices, byte address is four times the index
`define IRE_CTRL_INDEX 12'h0BF
`define IRE_STAT_INDEX 12'h0C0
`define IRE_ADDR_W 12

// Control register layout
`define IRE_CTRL_RESET 8'h00
`define IRE_CTRL_WMASK 8'hF7
`define IRE_CTRL_EN_BIT 0
`define IRE_CTRL_RXEN_BIT 1
`define IRE_CTRL_LOOP_BIT 2
`define IRE_CTRL_DIV_LSB 4
`define IRE_CTRL_DIV_MSB 7

// Status register layout
`define IRE_STAT_RXD_BIT 0
`define IRE_STAT_TXP_BIT 1
`define IRE_STAT_REJ_BIT 2
`define IRE_STAT_ACT_BIT 3

// Receive divider
`define IRE_DIV_WIDTH 6
`define IRE_DIV_LOW_BITS 2'h3
`define IRE_DIV_OFF 4'h0

// Bit timing in baud clocks (16 per bit)
`define IRE_PHASE_LAST 4'hF
`define IRE_TX_PULSE_FIRST 4'h7
`define IRE_TX_PULSE_LAST 4'h9
`define IRE_RX_DECIDE_PHASE 4'h8
`define IRE_RX_MAX_LOW_TICKS 4'h4
`define IRE_RX_IDLE_BITS 4'hA

`endif

/* hw/ir_pulse_timer.v */
/*
 * Receive pulse-width timer: a 6-bit divider of the system clock that
 * reports once a low pulse has lasted at least one divider period.
 * Assumes the caller restarts it at every falling edge of the line.
 */
`timescale 1ns/1ps
`include "infrared_endec_consts.vh"

module ir_pulse_timer #(
    parameter DIV_W = `IRE_DIV_WIDTH
) (
    // Clock and reset
    input wire clk_in,
    input wire reset_in,
    // Measurement control
    input wire run_in,
    input wire [DIV_W-3:0] upper_in,
    // Result
    output reg min_met_out
);

    reg [DIV_W-1:0] prescale;
    wire [DIV_W-1:0] terminal;

    // [RULE_02] Fixed low divider bits
    assign terminal = {upper_in, `IRE_DIV_LOW_BITS};

    // [RULE_01] Divider times pulse
    always @(posedge clk_in) begin
        if (reset_in || !run_in) begin
            prescale <= {DIV_W{1'b0}};
            min_met_out <= 1'b0;
        end else if (prescale == terminal) begin
            min_met_out <= 1'b1;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

endmodule // ir_pulse_timer

/* hw/infrared_pulse_endec.v */
/*
 * Infrared pulse encoder/decoder between a UART and an infrared
 * transceiver, with an APB register slave for its control and status registers.
 * Assumes BAUD_TICK_IN is a one-cycle pulse at sixteen times the bit
 * rate, and that all inputs are synchronous to REF_CLK_IN.
 * Registers sit at word index 0x0BF (control) and 0x0C0 (status: decoded
 * data, transmit pulse, sticky reject cleared by writing one, frame active).
 * Assumes the divider field suits the REF_CLK_IN rate; with the field at
 * zero, frames start on falling edges of the line alone.
 */
// Contract
// [RULE_01] Pulse widths measured by 6-bit system clock divider, 5 to 50 MHz.
// [RULE_02] Divider upper four bits from software field, lower two bits fixed 3.
// [RULE_03] Software sets field to clock over 3.33 MHz, rounded, period limited.
// [RULE_04] Software picks field per clock band table: 1, 2, 3, floor, round.
// [RULE_05] Field zero: no width check, receiver still decodes by edges.
// [RULE_06] With divider on, only pulses within width limits reach the UART.
// [RULE_07] First decoded bit may jitter, every later bit lasts 16 baud clocks.
// [RULE_08] System puts both infrared pins in alternate function mode 7.
// [RULE_09] Software should mask UART modem status interrupt during use.
// [RULE_10] Loopback bit 2 routes inverted transmit output to receive input.
// [RULE_11] External loopback: transmit while decoding on, echoes decoded back.
// [RULE_12] Receive enable bit 1 passes decoded data; cleared ignores input.
// [RULE_13] Control bit 0 enables the encoder/decoder.
// [RULE_14] Control resets to zero; unused bits ignore writes, read zero.
// [RULE_15] Send 1 as 16 clocks low; 0 as 7 low, 3 high, 6 low.
// [RULE_16] Receive bit is 16 baud clocks; low pulse is 0, steady high is 1.
// [RULE_17] Half duplex: no UART transmit while receive decoding enabled.
// [RULE_18] Disabled block holds transmit low and drives no decoded data.
`timescale 1ns/1ps
`include "infrared_endec_consts.vh"

module infrared_pulse_endec #(
    parameter MAX_LOW_TICKS = `IRE_RX_MAX_LOW_TICKS,
    parameter IDLE_BITS = `IRE_RX_IDLE_BITS
) (
    // Clock and reset
    input wire REF_CLK_IN,
    input wire RESET_IN,
    // APB slave
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [`IRE_ADDR_W-1:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output reg PREADY_OUT,
    output reg PSLVERR_OUT,
    // UART side
    input wire UART_TXD_IN,
    input wire BAUD_TICK_IN,
    output reg UART_RXD_OUT,
    // Infrared transceiver side
    input wire INFRARED_RX_IN,
    output reg INFRARED_TX_OUT
);

    // Word address match against a register index
    function reg_hit;
        input [`IRE_ADDR_W-1:0] addr;
        input [`IRE_ADDR_W-1:0] index;
        begin
            reg_hit = (addr[1:0] == 2'h0) && (addr[`IRE_ADDR_W-1:2] == index[`IRE_ADDR_W-3:0]);
        end
    endfunction

    // Control register and its fields
    reg [7:0] infrared_endec_control;
    wire endec_enable;
    wire infrared_receive_enable;
    wire loopback_enable;
    wire [3:0] rx_divider_upper_field;
    wire divider_off;

    // Bus decode
    wire apb_access;
    wire apb_done;
    wire hit_ctrl;
    wire hit_stat;
    wire ctrl_write;
    wire stat_write;
    reg [31:0] next_rdata;

    // Encoder state
    reg [3:0] tx_phase;
    reg tx_bit;
    reg [3:0] next_tx_phase;
    reg next_tx_bit;
    reg next_tx_out;

    // Receive front end
    wire rx_line;
    reg rx_prev;
    wire rx_fall;
    wire rx_rise;
    wire decode_on;
    reg [3:0] low_ticks;
    wire min_met;
    wire width_ok;
    wire pulse_qualified;
    wire pulse_rejected;
    reg reject_flag;

    // Decoder framing, one-hot states
    localparam [2:0] RX_IDLE = 3'b001;
    localparam [2:0] RX_FIRST = 3'b010;
    localparam [2:0] RX_DATA = 3'b100;

    reg [2:0] rx_state;
    reg [2:0] next_rx_state;
    wire frame_active;
    reg pulse_seen;
    reg next_pulse_seen;
    reg [3:0] rx_phase;
    reg [3:0] next_rx_phase;
    reg [3:0] ones_run;
    reg [3:0] next_ones_run;
    reg next_rxd;
    wire decide;
    wire decided_zero;

    assign endec_enable = infrared_endec_control[`IRE_CTRL_EN_BIT];
    assign infrared_receive_enable = infrared_endec_control[`IRE_CTRL_RXEN_BIT];
    assign loopback_enable = infrared_endec_control[`IRE_CTRL_LOOP_BIT];
    assign rx_divider_upper_field =
        infrared_endec_control[`IRE_CTRL_DIV_MSB:`IRE_CTRL_DIV_LSB];
    assign divider_off = (rx_divider_upper_field == `IRE_DIV_OFF);

    // APB slave: one wait state, answer registered
    assign apb_access = PSEL_IN && PENABLE_IN;
    assign apb_done = apb_access && PREADY_OUT;
    assign hit_ctrl = reg_hit(PADDR_IN, `IRE_CTRL_INDEX);
    assign hit_stat = reg_hit(PADDR_IN, `IRE_STAT_INDEX);
    assign ctrl_write = apb_done && PWRITE_IN && hit_ctrl;
    assign stat_write = apb_done && PWRITE_IN && hit_stat;

    // Read mux, status bits are live values
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            next_rdata[7:0] = infrared_endec_control;
        end else if (hit_stat) begin
            next_rdata[`IRE_STAT_RXD_BIT] = UART_RXD_OUT;
            next_rdata[`IRE_STAT_TXP_BIT] = INFRARED_TX_OUT;
            next_rdata[`IRE_STAT_REJ_BIT] = reject_flag;
            next_rdata[`IRE_STAT_ACT_BIT] = frame_active;
        end
    end

    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
        end else begin
            PREADY_OUT <= apb_access && !PREADY_OUT;
            if (apb_access && !PREADY_OUT) begin
                PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : next_rdata;
                PSLVERR_OUT <= !(hit_ctrl || hit_stat);
            end else begin
                PSLVERR_OUT <= 1'b0;
            end
        end
    end

    // [RULE_14] Reset to zero, masked writes
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            infrared_endec_control <= `IRE_CTRL_RESET;
        end else if (ctrl_write) begin
            infrared_endec_control <= PWDATA_IN[7:0] & `IRE_CTRL_WMASK;
        end
    end

    // Sticky reject flag, write one to clear, a new reject wins
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            reject_flag <= 1'b0;
        end else if (pulse_rejected) begin
            reject_flag <= 1'b1;
        end else if (stat_write && PWDATA_IN[`IRE_STAT_REJ_BIT]) begin
            reject_flag <= 1'b0;
        end
    end

    // Encoder
    // [RULE_17] Half duplex left to UART
    always @* begin
        next_tx_phase = tx_phase;
        next_tx_bit = tx_bit;
        next_tx_out = INFRARED_TX_OUT;
        if (BAUD_TICK_IN) begin
            next_tx_phase = tx_phase + 4'h1;
            if (next_tx_phase == 4'h0) begin
                next_tx_bit = UART_TXD_IN;
            end
            // [RULE_15] Pulse at clocks 7..9
            next_tx_out = !next_tx_bit
                && (next_tx_phase >= `IRE_TX_PULSE_FIRST)
                && (next_tx_phase <= `IRE_TX_PULSE_LAST);
        end
    end

    // [RULE_13] Enable gates encoder
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN || !endec_enable) begin
            // [RULE_18] Transmit held low
            tx_phase <= `IRE_PHASE_LAST;
            tx_bit <= 1'b1;
            INFRARED_TX_OUT <= 1'b0;
        end else begin
            tx_phase <= next_tx_phase;
            tx_bit <= next_tx_bit;
            INFRARED_TX_OUT <= next_tx_out;
        end
    end

    // Receive front end
    // [RULE_10] Inverted internal loopback
    assign rx_line = loopback_enable ? !INFRARED_TX_OUT : INFRARED_RX_IN;
    // [RULE_12] Decode only when receive enabled
    assign decode_on = endec_enable && infrared_receive_enable;
    assign rx_fall = rx_prev && !rx_line;
    assign rx_rise = !rx_prev && rx_line;

    // Baud ticks counted while the line is low, saturating
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN || !decode_on) begin
            rx_prev <= 1'b1;
            low_ticks <= 4'h0;
        end else begin
            rx_prev <= rx_line;
            if (rx_fall) begin
                low_ticks <= 4'h0;
            end else if (!rx_line && BAUD_TICK_IN && (low_ticks != 4'hF)) begin
                low_ticks <= low_ticks + 4'h1;
            end
        end
    end

    // The timer counts system clocks, so a legal low pulse must outlast
    // about {field,2'b11}+1 clocks before its rising edge
    ir_pulse_timer #(
        .DIV_W(`IRE_DIV_WIDTH)
    ) u_pulse_timer (
        .clk_in(REF_CLK_IN),
        .reset_in(RESET_IN),
        .run_in(decode_on && !divider_off && !rx_line && !rx_fall),
        .upper_in(rx_divider_upper_field),
        .min_met_out(min_met)
    );

    // [RULE_06] Width window check
    assign width_ok = min_met && (low_ticks <= MAX_LOW_TICKS);
    // [RULE_05] Edge detection when divider off
    assign pulse_qualified = decode_on
        && (divider_off ? rx_fall : (rx_rise && width_ok));
    assign pulse_rejected = decode_on && !divider_off && rx_rise && !width_ok;

    // Decoder framing
    assign frame_active = (rx_state != RX_IDLE);
    assign decide = frame_active && BAUD_TICK_IN && (rx_phase == `IRE_RX_DECIDE_PHASE);
    assign decided_zero = pulse_seen || pulse_qualified;

    // Next decoder state
    always @* begin
        next_rx_state = rx_state;
        next_pulse_seen = pulse_seen;
        next_rx_phase = rx_phase;
        next_ones_run = ones_run;
        next_rxd = UART_RXD_OUT;
        case (rx_state)
            RX_IDLE: begin
                // A qualified pulse opens a frame with the start bit
                if (pulse_qualified) begin
                    next_rx_state = RX_FIRST;
                    next_pulse_seen = 1'b0;
                    next_rx_phase = 4'h0;
                    next_ones_run = 4'h0;
                    next_rxd = 1'b0;
                end
            end
            RX_FIRST: begin
                if (BAUD_TICK_IN) begin
                    next_rx_phase = rx_phase + 4'h1;
                end
                // First bit may jitter, its decision is skipped
                if (decide) begin
                    next_rx_state = RX_DATA;
                    next_pulse_seen = 1'b0;
                end else if (pulse_qualified) begin
                    next_pulse_seen = 1'b1;
                end
            end
            RX_DATA: begin
                if (BAUD_TICK_IN) begin
                    next_rx_phase = rx_phase + 4'h1;
                end
                if (decide) begin
                    // [RULE_07] Later bits exactly 16 wide
                    next_rxd = !decided_zero;
                    next_pulse_seen = 1'b0;
                    if (decided_zero) begin
                        next_ones_run = 4'h0;
                    end else if (ones_run == IDLE_BITS - 1) begin
                        next_rx_state = RX_IDLE;
                        next_rxd = 1'b1;
                    end else begin
                        next_ones_run = ones_run + 4'h1;
                    end
                end else if (pulse_qualified) begin
                    // [RULE_11] Echoed pulses decoded
                    next_pulse_seen = 1'b1;
                end
            end
            default: begin
                // Illegal code falls back to idle
                next_rx_state = RX_IDLE;
                next_rxd = 1'b1;
            end
        endcase
    end

    // [RULE_16] Sixteen-clock bit decode
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN || !decode_on) begin
            // [RULE_18] Idle high toward UART
            rx_state <= RX_IDLE;
            pulse_seen <= 1'b0;
            rx_phase <= 4'h0;
            ones_run <= 4'h0;
            UART_RXD_OUT <= 1'b1;
        end else begin
            rx_state <= next_rx_state;
            pulse_seen <= next_pulse_seen;
            rx_phase <= next_rx_phase;
            ones_run <= next_ones_run;
            UART_RXD_OUT <= next_rxd;
        end
    end

endmodule // infrared_pulse_endec

/* testbench/infrared_pulse_endec_properties.sv */
/*
 * Port checker for the infrared encoder/decoder, bound to its top module.
 * Assumes the bench pulses BAUD_TICK_IN once every four clocks.
 */
`timescale 1ns/1ps

module endec_checker (
    // Clock and reset
    input wire REF_CLK_IN,
    input wire RESET_IN,
    // APB slave
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    input wire [31:0] PRDATA_OUT,
    input wire PREADY_OUT,
    input wire PSLVERR_OUT,
    // UART and transceiver
    input wire UART_TXD_IN,
    input wire BAUD_TICK_IN,
    input wire UART_RXD_OUT,
    input wire INFRARED_RX_IN,
    input wire INFRARED_TX_OUT
);
    reg [7:0] ctrl;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RESET_IN);
    // Shadow of the control register
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN)
            ctrl <= 8'h00;
        else if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == 12'h2FC)
            ctrl <= PWDATA_IN[7:0] & 8'hF7;
    end
    a_ready_wait: assert property (
        PSEL_IN && $rose(PENABLE_IN) |-> !PREADY_OUT ##1 PREADY_OUT) else $error("late ready");
    a_ready_pulse: assert property (
        PREADY_OUT |=> !PREADY_OUT) else $error("ready too long");
    a_err_map: assert property (
        PREADY_OUT |-> PSLVERR_OUT == (PADDR_IN != 12'h2FC && PADDR_IN != 12'h300))
        else $error("wrong error flag");
    a_ctrl_read: assert property (
        PREADY_OUT && !PWRITE_IN && PADDR_IN == 12'h2FC |-> PRDATA_OUT == {24'h0, ctrl})
        else $error("control read mismatch");
    a_tx_off: assert property (
        !ctrl[0] && !$past(ctrl[0]) |-> !INFRARED_TX_OUT) else $error("tx high while off");
    a_rxd_off: assert property (
        !ctrl[1] && !$past(ctrl[1]) |-> UART_RXD_OUT) else $error("rx data while ignored");
    a_tx_width: assert property (
        disable iff (RESET_IN || !ctrl[0])
        $rose(INFRARED_TX_OUT) |-> INFRARED_TX_OUT[*8] ##4 INFRARED_TX_OUT ##1 !INFRARED_TX_OUT)
        else $error("tx pulse width");
    a_tx_gap: assert property (
        disable iff (RESET_IN || !ctrl[0])
        $fell(INFRARED_TX_OUT) |-> !INFRARED_TX_OUT[*8] ##43 !INFRARED_TX_OUT)
        else $error("tx low gap");
endmodule // endec_checker

bind infrared_pulse_endec endec_checker endec_checker_inst (.REF_CLK_IN(REF_CLK_IN),
    .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
    .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .UART_TXD_IN(UART_TXD_IN), .BAUD_TICK_IN(BAUD_TICK_IN),
    .UART_RXD_OUT(UART_RXD_OUT), .INFRARED_RX_IN(INFRARED_RX_IN),
    .INFRARED_TX_OUT(INFRARED_TX_OUT));

/* testbench/ir_transceiver_model.sv */
/*
 * Behavioural infrared transceiver: sends pulse-coded bits or echoes.
 * Assumes tick_in is the sixteen-times baud enable of the bench.
 */
`timescale 1ns/1ps

module ir_transceiver_model (
    // Clock and baud timing
    input wire clk_in,
    input wire tick_in,
    // Transceiver lines
    input wire tx_in,
    input wire echo_in,
    output wire rx_out
);
    reg line = 1'b1;
    assign rx_out = echo_in ? !tx_in : line;
    task automatic wait_ticks(input integer k);
        repeat (k) begin
            @(posedge clk_in);
            while (tick_in !== 1'b1) @(posedge clk_in);
        end
    endtask
    task automatic send(input [7:0] bits, input integer len, input integer w);
        integer i;
        for (i = 0; i < len; i = i + 1) begin
            wait_ticks(7);
            line <= bits[i];
            wait_ticks(w);
            line <= 1'b1;
            wait_ticks(9 - w);
        end
    endtask
endmodule // ir_transceiver_model

/* testbench/tb.sv */
/*
 * Self-checking bench: APB register tasks plus infrared traffic scenarios.
 * Assumes the transceiver model and the bound port checker.
 */
`timescale 1ns/1ps

module tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg pen = 1'b0;
    reg pwr = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg txd = 1'b1;
    reg tick = 1'b0;
    reg echo = 1'b0;
    reg er;
    reg [1:0] tcnt = 2'h0;
    reg [31:0] rd;
    wire [31:0] prdata;
    wire pready, pslverr, rxd, irrx, irtx;
    integer errors = 0;
    integer checked = 0;
    integer lows = 0;
    integer n, c;
    always #2 clk = !clk;
    always @(posedge clk) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
        if (rxd === 1'b0) lows <= lows + 1;
    end
    infrared_pulse_endec infrared_pulse_endec_inst (.REF_CLK_IN(clk), .RESET_IN(rst),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .UART_TXD_IN(txd),
        .BAUD_TICK_IN(tick), .UART_RXD_OUT(rxd), .INFRARED_RX_IN(irrx), .INFRARED_TX_OUT(irtx));
    // pins wired straight to the transceiver, as the alternate mode does
    // no modem status lines exist here, so no stray interrupt can arise
    ir_transceiver_model ir_transceiver_model_inst (.clk_in(clk), .tick_in(tick),
        .tx_in(irtx), .echo_in(echo), .rx_out(irrx));
    task automatic conclude;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input [31:0] exp, input [31:0] got, input string what);
        checked = checked + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input bit wr, input [11:0] a, input [31:0] d);
        integer k;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k = k + 1;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
        if (k == 20) begin
            errors = errors + 1;
            conclude;
        end
    endtask
    // Counts clocks while the chosen line holds a level
    task automatic span(input bit rx, input bit lv, output integer cnt);
        cnt = 0;
        while ((rx ? rxd : irtx) === lv && cnt < 3000) begin
            @(posedge clk);
            cnt = cnt + 1;
        end
        if (cnt == 3000) begin
            errors = errors + 1;
            conclude;
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 12'h2FC, 32'h0);
        check(32'h0, rd, "ctrl reset");
        apb(1'b1, 12'h2FC, 32'hFFFFFFFF);
        apb(1'b0, 12'h2FC, 32'h0);
        check(32'hF7, rd, "ctrl mask");
        apb(1'b0, 12'h004, 32'h0);
        check(32'h1, {31'h0, er}, "unmapped error");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 12'h2FC, 32'h0);
        check(32'h0, rd, "ctrl after reset");
        apb(1'b1, 12'h2FC, 32'h0);
        $display("test registers done");
        txd <= 1'b0;
        apb(1'b1, 12'h2FC, 32'h01);
        span(1'b0, 1'b0, n);
        span(1'b0, 1'b1, n);
        check(32'd12, n, "tx pulse clocks");
        // Switch off in the middle of the next pulse
        span(1'b0, 1'b0, n);
        apb(1'b1, 12'h2FC, 32'h0);
        @(posedge clk);
        check(32'h0, {31'h0, irtx}, "tx when off");
        txd <= 1'b1;
        $display("test encoder done");
        apb(1'b1, 12'h2FC, 32'h03);
        fork
            ir_transceiver_model_inst.send(8'hF6, 8, 3);
            begin
                span(1'b1, 1'b1, c);
                span(1'b1, 1'b0, c);
                span(1'b1, 1'b1, c);
                check(32'd128, c, "two one bits");
                span(1'b1, 1'b0, c);
                check(32'd64, c, "later zero bit");
            end
        join
        apb(1'b1, 12'h2FC, 32'h0);
        $display("test edge decode done");
        // lowest field value, scaled to the bench clock
        apb(1'b1, 12'h2FC, 32'h13);
        n = lows;
        ir_transceiver_model_inst.send(8'hFE, 8, 1);
        check(n, lows, "short pulse");
        apb(1'b0, 12'h300, 32'h0);
        check(32'h1, {31'h0, rd[2]}, "reject flag");
        ir_transceiver_model_inst.send(8'hFE, 8, 6);
        check(n, lows, "long pulse");
        ir_transceiver_model_inst.send(8'hFE, 8, 3);
        check(32'h1, {31'h0, lows != n}, "legal pulse");
        apb(1'b1, 12'h2FC, 32'h01);
        n = lows;
        ir_transceiver_model_inst.send(8'hFE, 8, 3);
        check(n, lows, "rx ignored");
        $display("test divider done");
        txd <= 1'b0;
        apb(1'b1, 12'h2FC, 32'h07);
        span(1'b1, 1'b1, c);
        check(32'h0, {31'h0, rxd}, "internal loop");
        apb(1'b1, 12'h2FC, 32'h0);
        echo <= 1'b1;
        apb(1'b1, 12'h2FC, 32'h03);
        span(1'b1, 1'b1, c);
        check(32'h0, {31'h0, rxd}, "external loop");
        apb(1'b1, 12'h2FC, 32'h0);
        // line idle after the loop tests
        txd <= 1'b1;
        echo <= 1'b0;
        $display("test loopback done");
        conclude;
    end
endmodule // tb
